// File: design/obtl_flash_fetch.sv
// Read-only sequencer fetching option bytes and trim bytes from flash.
// Assumes the flash holds flash_rdata valid while flash_ack is high.
`timescale 1ns/1ps
`default_nettype none
module obtl_flash_fetch (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	obtl_load_if.fetch       lif,
	output logic             flash_rd,
	output logic             flash_info,
	output logic [15:0]      flash_addr,
	input  wire logic        flash_ack,
	input  wire logic [7:0]  flash_rdata
);
	obtl_pkg::obtl_fetch_t state;
	obtl_pkg::obtl_fetch_t next_state;
	logic [5:0]            slot;
	logic                  last;

	// No write or erase strobe exists here, so flash content is never disturbed
	assign flash_rd   = state == obtl_pkg::FETCH_REQ; // RULE_12
	assign flash_info = slot >= obtl_pkg::OPT_SLOTS; // RULE_06
	assign flash_addr = obtl_pkg::obtl_slot_addr(slot); // RULE_13 RULE_11
	assign last       = slot == obtl_pkg::LAST_SLOT;
	assign lif.busy   = state != obtl_pkg::FETCH_IDLE;

	always_comb begin
		next_state = state;
		case (state)
			obtl_pkg::FETCH_IDLE: if (lif.start) next_state = obtl_pkg::FETCH_REQ;
			obtl_pkg::FETCH_REQ:  if (flash_ack) next_state = last ? obtl_pkg::FETCH_IDLE : obtl_pkg::FETCH_WAIT;
			obtl_pkg::FETCH_WAIT: next_state = obtl_pkg::FETCH_REQ;
			default:              next_state = obtl_pkg::FETCH_IDLE;
		endcase
		// A restart abandons any sequence in flight
		if (lif.start)
			next_state = obtl_pkg::FETCH_REQ;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state          <= obtl_pkg::FETCH_IDLE;
			slot           <= 6'h00;
			lif.byte_valid <= 1'b0;
			lif.slot       <= 6'h00;
			lif.data       <= 8'h00;
		end else begin
			state          <= next_state;
			lif.byte_valid <= flash_rd && flash_ack && !lif.start;
			if (flash_rd && flash_ack) begin
				lif.slot <= slot;
				lif.data <= flash_rdata;
			end
			if (lif.start)
				slot <= 6'h00;
			else if (flash_rd && flash_ack && !last)
				slot <= slot + 6'h01;
		end
	end
endmodule : obtl_flash_fetch
`default_nettype wire

// File: design/obtl_loader.sv
// Top of the option bit and trim loader: reset-time load, CPU hold, APB trim access.
// Assumes rst covers system and power-on reset; stop_recovery is a clk_sys pulse.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01 - Every reset event reloads option bytes
// RULE_02 - Load finishes before CPU leaves reset
// RULE_03 - Option holding registers invisible to software
// RULE_04 - Flash changes apply only after reset
// RULE_05 - User options from first two bytes
// RULE_06 - Trim values from information page
// RULE_07 - Software trim edits lost on reset
// RULE_08 - Software writes trim index 00H-1FH first
// RULE_09 - Data write replaces selected trim byte
// RULE_10 - Data read returns selected trim byte
// RULE_11 - Only information locations 20-3F reachable
// RULE_12 - Serial bytes survive mass erase
// RULE_13 - Options read at 0000H and 0001H
// RULE_14 - Bit 7 picks watchdog interrupt or reset
// RULE_15 - During load hold CPU, ignore trim accesses
module obtl_loader (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         stop_recovery,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [15:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	output logic              flash_rd,
	output logic              flash_info,
	output logic      [15:0]  flash_addr,
	input  wire logic         flash_ack,
	input  wire logic [7:0]   flash_rdata,
	output logic              cpu_reset_hold,
	output logic      [7:0]   option_byte0,
	output logic      [7:0]   option_byte1,
	output logic              watchdog_timeout_action,
	output logic      [255:0] trim_values
);
	obtl_load_if lif ();

	obtl_pkg::obtl_main_t state;
	obtl_pkg::obtl_main_t next_state;
	logic                 kick;
	logic [obtl_pkg::TRIM_IDX_W-1:0] trim_index;
	logic                 running;
	logic                 load_trim;
	logic                 load_last;
	logic                 setup;
	logic                 access;
	logic                 hit_stat;
	logic                 hit_addr;
	logic                 hit_data;
	logic                 mapped;
	logic                 sw_wr_index;
	logic                 sw_wr_data;
	logic                 store_wr;
	logic [obtl_pkg::TRIM_IDX_W-1:0] store_idx;
	logic [7:0]           store_data;
	logic [5:0]           trim_slot;
	logic [7:0]           trim_rd;
	logic [31:0]          next_prdata;

	obtl_flash_fetch u_fetch (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.lif         (lif.fetch),
		.flash_rd    (flash_rd),
		.flash_info  (flash_info),
		.flash_addr  (flash_addr),
		.flash_ack   (flash_ack),
		.flash_rdata (flash_rdata)
	);

	obtl_trim_store u_trim (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.wr_en      (store_wr),
		.wr_idx     (store_idx),
		.wr_data    (store_data),
		.rd_idx     (trim_index),
		.rd_data    (trim_rd),
		.all_values (trim_values)
	);

	// Load sequencing
	assign lif.start = kick; // RULE_01
	assign running   = state == obtl_pkg::MAIN_RUN;
	assign load_trim = lif.byte_valid && lif.slot >= obtl_pkg::OPT_SLOTS; // RULE_06
	assign load_last = lif.byte_valid && lif.slot == obtl_pkg::LAST_SLOT;

	always_comb begin
		next_state = state;
		case (state)
			obtl_pkg::MAIN_LOAD: if (load_last && !kick) next_state = obtl_pkg::MAIN_RUN; // RULE_02
			obtl_pkg::MAIN_RUN:  if (kick) next_state = obtl_pkg::MAIN_LOAD;
			default:             next_state = obtl_pkg::MAIN_LOAD;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state          <= obtl_pkg::MAIN_LOAD;
			kick           <= 1'b1; // RULE_01
			cpu_reset_hold <= 1'b1; // RULE_02
		end else begin
			state          <= next_state;
			kick           <= stop_recovery; // RULE_01
			cpu_reset_hold <= next_state != obtl_pkg::MAIN_RUN; // RULE_02 RULE_15
		end
	end

	// Option holding registers: no bus path reaches them, and they change only
	// while a load runs, so flash edits wait for the next reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			option_byte0 <= obtl_pkg::OPT_ERASED; // RULE_14
			option_byte1 <= obtl_pkg::OPT_ERASED;
		end else if (lif.byte_valid && !running) begin // RULE_04 RULE_03
			if (lif.slot == 6'h00)
				option_byte0 <= lif.data; // RULE_05 RULE_13
			if (lif.slot == 6'h01)
				option_byte1 <= lif.data; // RULE_05 RULE_13
		end
	end

	assign watchdog_timeout_action = option_byte0[obtl_pkg::WDT_ACTION_BIT]; // RULE_14

	// APB decode; zero wait states, read data captured in the setup cycle
	assign setup    = psel && !penable;
	assign access   = psel && penable;
	assign hit_stat = obtl_pkg::obtl_reg_hit(paddr, obtl_pkg::LOAD_STAT_IDX);
	assign hit_addr = obtl_pkg::obtl_reg_hit(paddr, obtl_pkg::TRIM_ADDR_IDX);
	assign hit_data = obtl_pkg::obtl_reg_hit(paddr, obtl_pkg::TRIM_DATA_IDX);
	assign mapped   = hit_stat || hit_addr || hit_data; // RULE_03
	assign pready   = 1'b1;
	assign pslverr  = access && !mapped;

	// Trim accesses during a load are dropped silently
	assign sw_wr_index = access && pwrite && hit_addr && running; // RULE_15
	assign sw_wr_data  = access && pwrite && hit_data && running; // RULE_09 RULE_15

	// Loader owns the store while loading, software only afterwards
	assign store_wr   = load_trim || sw_wr_data;
	assign trim_slot  = lif.slot - obtl_pkg::OPT_SLOTS;
	assign store_idx  = load_trim ? trim_slot[obtl_pkg::TRIM_IDX_W-1:0] : trim_index; // RULE_09
	assign store_data = load_trim ? lif.data : pwdata[7:0]; // RULE_09

	always_ff @(posedge clk_sys) begin
		if (rst)
			trim_index <= 5'h00;
		else if (sw_wr_index)
			// Five bits only, so nothing outside the trim window is reachable
			trim_index <= pwdata[obtl_pkg::TRIM_IDX_W-1:0]; // RULE_08 RULE_11
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (hit_stat) begin
			next_prdata[obtl_pkg::STAT_DONE_BIT] = running;
			next_prdata[obtl_pkg::STAT_BUSY_BIT] = lif.busy;
		end
		if (hit_addr && running)
			next_prdata[obtl_pkg::TRIM_IDX_W-1:0] = trim_index; // RULE_15
		if (hit_data && running)
			next_prdata[7:0] = trim_rd; // RULE_10 RULE_15
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (setup)
			prdata <= pwrite ? 32'h0000_0000 : next_prdata; // RULE_10
	end
endmodule : obtl_loader
`default_nettype wire

// File: design/obtl_trim_store.sv
// Working copies of the 32 trim bytes, one write and one read port.
// Assumes the writer arbitrates between loader and software.
`timescale 1ns/1ps
`default_nettype none
module obtl_trim_store (
	input  wire logic                            clk_sys,
	input  wire logic                            rst,
	input  wire logic                            wr_en,
	input  wire logic [obtl_pkg::TRIM_IDX_W-1:0] wr_idx,
	input  wire logic [7:0]                      wr_data,
	input  wire logic [obtl_pkg::TRIM_IDX_W-1:0] rd_idx,
	output logic      [7:0]                      rd_data,
	output logic      [8*obtl_pkg::TRIM_COUNT-1:0] all_values
);
	logic [7:0] mem [obtl_pkg::TRIM_COUNT];

	assign rd_data = mem[rd_idx];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// Old software edits vanish; the reload restores factory values
			for (int i = 0; i < obtl_pkg::TRIM_COUNT; i++) begin
				mem[i] <= obtl_pkg::TRIM_RESET; // RULE_07
			end
		end else if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_comb begin
		for (int i = 0; i < obtl_pkg::TRIM_COUNT; i++) begin
			all_values[8*i +: 8] = mem[i];
		end
	end
endmodule : obtl_trim_store
`default_nettype wire

// File: pkg/obtl_load_if.sv
// Carries fetched bytes from the flash fetch sequencer to the loader core.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface obtl_load_if;
	logic       start;
	logic       busy;
	logic       byte_valid;
	logic [5:0] slot;
	logic [7:0] data;
	modport ctrl  (output start, input busy, input byte_valid, input slot, input data);
	modport fetch (input start, output busy, output byte_valid, output slot, output data);
endinterface : obtl_load_if
`default_nettype wire

// File: pkg/obtl_pkg.sv
// Shared constants and types of the option bit and trim loader.
// Assumes one 10 MHz system clock and an APB register slave with 32-bit data.
package obtl_pkg;
	localparam logic [11:0] LOAD_STAT_IDX  = 12'hff5;
	localparam logic [11:0] TRIM_ADDR_IDX  = 12'hff6;
	localparam logic [11:0] TRIM_DATA_IDX  = 12'hff7;
	localparam logic [15:0] OPT_ADDR0      = 16'h0000;
	localparam logic [15:0] OPT_ADDR1      = 16'h0001;
	localparam logic [15:0] TRIM_INFO_BASE = 16'h0020;
	localparam int          TRIM_COUNT     = 32;
	localparam int          TRIM_IDX_W     = 5;
	localparam logic [5:0]  OPT_SLOTS      = 6'h02;
	localparam logic [5:0]  LAST_SLOT      = 6'h21;
	localparam logic [7:0]  OPT_ERASED     = 8'hff;
	localparam logic [7:0]  TRIM_RESET     = 8'h00;
	localparam int          WDT_ACTION_BIT = 7;
	localparam int          STAT_DONE_BIT  = 0;
	localparam int          STAT_BUSY_BIT  = 1;

	typedef enum logic [1:0] {
		MAIN_LOAD = 2'b01,
		MAIN_RUN  = 2'b10
	} obtl_main_t;

	typedef enum logic [2:0] {
		FETCH_IDLE = 3'b001,
		FETCH_REQ  = 3'b010,
		FETCH_WAIT = 3'b100
	} obtl_fetch_t;

	// Byte address of a register is four times its index
	function automatic logic obtl_reg_hit(input logic [15:0] addr, input logic [11:0] idx);
		return addr == {2'h0, idx, 2'h0};
	endfunction : obtl_reg_hit

	// Flash location of a fetch slot: two option bytes, then the trim window
	function automatic logic [15:0] obtl_slot_addr(input logic [5:0] slot);
		if (slot < OPT_SLOTS)
			return OPT_ADDR0 + {10'h000, slot};
		return TRIM_INFO_BASE + {10'h000, slot - OPT_SLOTS};
	endfunction : obtl_slot_addr
endpackage : obtl_pkg

// File: sim/obtl_flash_model.sv
// Behavioural flash: program bytes and information page, prompt or slow ack.
// Assumes the bench fills prog and info before the first load.
`timescale 1ns/1ps
`default_nettype none
module obtl_flash_model (
	input  wire logic        clk_sys,
	input  wire logic        slow,
	input  wire logic        flash_rd,
	input  wire logic        flash_info,
	input  wire logic [15:0] flash_addr,
	output logic             flash_ack,
	output logic [7:0]       flash_rdata
);
	logic [7:0] prog [0:1];
	logic [7:0] info [0:63];
	logic [1:0] cnt;
	logic [7:0] last;
	wire  [7:0] word = flash_info ? info[flash_addr[5:0]] : prog[flash_addr[0]];
	assign flash_ack = flash_rd && (!slow || cnt == 2'h3);
	// Idle bus shows the inverse of the last byte, never a stale copy
	assign flash_rdata = flash_ack ? word : ~last;
	always_ff @(posedge clk_sys) begin
		cnt <= (flash_rd && !flash_ack) ? cnt + 2'h1 : 2'h0;
		if (flash_ack)
			last <= word;
	end
endmodule : obtl_flash_model
`default_nettype wire

// File: sim/obtl_loader_bench.sv
// Self-checking bench: APB master, flash model, reset and stop-recovery loads.
// Assumes zero or more APB wait states; every wait is bounded.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module obtl_loader_bench;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	logic         stop_recovery = 1'b0;
	logic         slow = 1'b0;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [15:0]  paddr = 16'h0000;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         flash_rd;
	logic         flash_info;
	logic [15:0]  flash_addr;
	logic         flash_ack;
	logic [7:0]   flash_rdata;
	logic         cpu_reset_hold;
	logic [7:0]   option_byte0;
	logic [7:0]   option_byte1;
	logic         watchdog_timeout_action;
	logic [255:0] trim_values;
	logic [31:0]  rd;
	logic         err;
	int           n_mismatch = 0;
	int           n_tests = 0;
	obtl_loader DUT (
		.clk_sys                 (clk_sys),
		.rst                     (rst),
		.stop_recovery           (stop_recovery),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.prdata                  (prdata),
		.pready                  (pready),
		.pslverr                 (pslverr),
		.flash_rd                (flash_rd),
		.flash_info              (flash_info),
		.flash_addr              (flash_addr),
		.flash_ack               (flash_ack),
		.flash_rdata             (flash_rdata),
		.cpu_reset_hold          (cpu_reset_hold),
		.option_byte0            (option_byte0),
		.option_byte1            (option_byte1),
		.watchdog_timeout_action (watchdog_timeout_action),
		.trim_values             (trim_values)
	);
	obtl_flash_model flash (
		.clk_sys     (clk_sys),
		.slow        (slow),
		.flash_rd    (flash_rd),
		.flash_info  (flash_info),
		.flash_addr  (flash_addr),
		.flash_ack   (flash_ack),
		.flash_rdata (flash_rdata)
	);
	initial forever #50 clk_sys = ~clk_sys;
	function automatic logic [7:0] tv(input int i);
		return 8'(i * 19 + 5);
	endfunction : tv
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask : apb
	// Edge first: a hold raised by this very edge is not yet visible
	task automatic wait_load();
		int k;
		for (k = 0; k < 1000; k++) begin
			@(posedge clk_sys);
			if (cpu_reset_hold === 1'b0)
				break;
		end
		if (k == 1000) begin
			n_mismatch++;
			tally_and_finish();
		end
	endtask : wait_load
	task automatic check_load(input logic [7:0] o0, input logic [7:0] o1);
		`CHK(option_byte0, o0)
		`CHK(option_byte1, o1)
		`CHK(watchdog_timeout_action, o0[7])
		for (int i = 0; i < 32; i++)
			`CHK(trim_values[8*i +: 8], tv(i))
	endtask : check_load
	initial begin
		for (int i = 0; i < 64; i++)
			flash.info[i] = tv(i - 32);
		flash.prog[0] = 8'h7e;
		flash.prog[1] = 8'h3c;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		`CHK(cpu_reset_hold, 1'b1)
		apb(1'b1, 16'h3fd8, 32'h3);
		apb(1'b0, 16'h3fdc, 32'h0);
		`CHK(rd, 32'h0)
		`CHK(err, 1'b0)
		wait_load();
		check_load(8'h7e, 8'h3c);
		// Index written during the load must have been dropped
		apb(1'b0, 16'h3fd8, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, 16'h3fd4, 32'h0);
		`CHK(rd, 32'h1)
		for (int i = 0; i < 32; i++) begin
			apb(1'b1, 16'h3fd8, 32'(i));
			apb(1'b0, 16'h3fdc, 32'h0);
			`CHK(rd, {24'h0, tv(i)})
		end
		apb(1'b1, 16'h3fd8, 32'h25);
		apb(1'b0, 16'h3fd8, 32'h0);
		`CHK(rd, 32'h5)
		apb(1'b0, 16'h3fdc, 32'h0);
		`CHK(rd, {24'h0, tv(5)})
		apb(1'b1, 16'h3fd8, 32'h1f);
		apb(1'b1, 16'h3fdc, 32'hc3);
		apb(1'b0, 16'h3fdc, 32'h0);
		// Store settles one edge after the write, so look after the read
		`CHK(trim_values[255:248], 8'hc3)
		`CHK(rd, 32'hc3)
		apb(1'b0, 16'h3fe0, 32'h0);
		`CHK(err, 1'b1)
		`CHK(rd, 32'h0)
		// Erased page 0 in flash must not show until a reload
		flash.prog[0] = 8'hff;
		flash.prog[1] = 8'hff;
		repeat (3) @(posedge clk_sys);
		`CHK(option_byte0, 8'h7e)
		slow <= 1'b1;
		stop_recovery <= 1'b1;
		@(posedge clk_sys);
		stop_recovery <= 1'b0;
		@(posedge clk_sys);
		wait_load();
		check_load(8'hff, 8'hff);
		`CHK(trim_values[255:248], tv(31))
		// A software edit that the following resets must wipe out
		apb(1'b1, 16'h3fd8, 32'h1f);
		apb(1'b1, 16'h3fdc, 32'h5a);
		rst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		wait_load();
		check_load(8'hff, 8'hff);
		`CHK(trim_values[255:248], tv(31))
		tally_and_finish();
	end
endmodule : obtl_loader_bench
bind obtl_loader obtl_loader_properties chk (
	.clk_sys                 (clk_sys),
	.rst                     (rst),
	.psel                    (psel),
	.penable                 (penable),
	.paddr                   (paddr),
	.pready                  (pready),
	.pslverr                 (pslverr),
	.flash_rd                (flash_rd),
	.flash_info              (flash_info),
	.flash_addr              (flash_addr),
	.flash_ack               (flash_ack),
	.cpu_reset_hold          (cpu_reset_hold),
	.option_byte0            (option_byte0),
	.option_byte1            (option_byte1),
	.watchdog_timeout_action (watchdog_timeout_action),
	.trim_values             (trim_values)
);
`default_nettype wire

// File: sim/obtl_loader_properties.sv
// Port-level checker of the option bit and trim loader.
// Assumes one clk_sys domain with synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module obtl_loader_properties (
	input wire logic         clk_sys,
	input wire logic         rst,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic [15:0]  paddr,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire logic         flash_rd,
	input wire logic         flash_info,
	input wire logic [15:0]  flash_addr,
	input wire logic         flash_ack,
	input wire logic         cpu_reset_hold,
	input wire logic [7:0]   option_byte0,
	input wire logic [7:0]   option_byte1,
	input wire logic         watchdog_timeout_action,
	input wire logic [255:0] trim_values
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire mapped = paddr == 16'h3fd4 || paddr == 16'h3fd8 || paddr == 16'h3fdc;
	pready_fixed_a: assert property (pready) else $error("pready low");
	err_phase_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
	unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr) else $error("no error");
	fetch_hold_a: assert property (flash_rd && !flash_ack |=> flash_rd && $stable(flash_addr))
		else $error("flash request dropped");
	fetch_gap_a: assert property (flash_rd && flash_ack |=> !flash_rd) else $error("no idle cycle");
	fetch_window_a: assert property (flash_rd |-> (!flash_info && flash_addr <= 16'h0001)
		|| (flash_info && flash_addr >= 16'h0020 && flash_addr <= 16'h003f)) else $error("bad flash address");
	fetch_in_hold_a: assert property (flash_rd |-> cpu_reset_hold) else $error("fetch after release");
	opt_frozen_a: assert property (!cpu_reset_hold && !$past(cpu_reset_hold)
		|-> $stable(option_byte0) && $stable(option_byte1)) else $error("options changed in run");
	wdt_bit_a: assert property (watchdog_timeout_action == option_byte0[7]) else $error("wdt bit");
	reset_clear_a: assert property (disable iff (1'b0) rst |=> cpu_reset_hold && trim_values == 256'h0)
		else $error("reset values");
	cover property (flash_rd && !flash_ack);
	cover property ($fell(cpu_reset_hold));
	cover property (psel && penable && pslverr);
endmodule : obtl_loader_properties
`default_nettype wire
